// File: src/rcs_clock_select.sv
// Clock source select, start-up delay and oscillator trim with APB registers.
// Assumes fuses are static straps, factory byte is stable during reset, single core clock.
//
// Functional notes
// - Source codes 1 to 4 pick the internal RC at 1, 2, 4 or 8 MHz with no external parts.
// - Delivered fuses select the 1 MHz RC and the slowly rising power start-up code.
// - Each reset copies the factory 1 MHz calibration byte into the trim register.
// - The eight trim bits raise the RC frequency from lowest at zero to highest at all ones.
// - Memory write timing comes from the calibrated RC whatever source clocks the core.
// - RC start-up takes 6 cycles from sleep and adds none, 4.1 ms or 65 ms after reset.
// - Source code 0 takes the system clock straight from the crystal input pin.
// - External clock start-up takes 6 cycles from sleep and adds none, 4.1 ms or 65 ms after reset.
// - The watchdog oscillator still clocks the watchdog; the reset time-out counts core clock cycles.
// - In legacy compatibility mode the trim register is absent from the map.
`timescale 1ns/1ps
`default_nettype none
module rcs_clock_select #(
  parameter int unsigned SHORT_CYC = rcs_pkg::DLY_SHORT_CYC,
  parameter int unsigned LONG_CYC = rcs_pkg::DLY_LONG_CYC
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Fuse straps and modes
  input wire logic [3:0] clock_source_select_fuses_i,
  input wire logic [1:0] startup_time_fuses_i,
  input wire logic oscillator_option_fuse_i,
  input wire logic legacy_mode_i,
  input wire logic [7:0] factory_cal_byte_i,
  // Sleep handshake
  input wire logic sleep_i,
  input wire logic wake_i,
  // Clock sources
  input wire logic rc_osc_clk_i,
  input wire logic crystal_input_pin_i,
  input wire logic watchdog_osc_clk_i,
  // Outputs
  output logic [7:0] trim_value_o,
  output logic [1:0] rc_range_o,
  output logic rc_enable_o,
  output logic ext_select_o,
  output logic nvm_timing_clk_o,
  output logic watchdog_clk_o,
  output logic sys_clk_o,
  output logic clock_ready_o,
  output logic fuse_error_o
);
  import rcs_pkg::*;

  typedef enum logic [1:0] {
    ST_RESET_WAIT,
    ST_RUN,
    ST_SLEEP,
    ST_WAKE_WAIT
  } rcs_state_t;

  typedef struct packed {
    rcs_state_t state;
    logic [7:0] trim;
    logic [3:0] src;
    logic [1:0] startup_time_fuses;
    logic opt;
    logic src_bad;
    logic [31:0] count;
    logic [31:0] target;
    logic clk_en;
    logic ext_prev;
    logic [31:0] rdata;
    logic [31:0] wake_log;
  } rcs_core_t;

  rcs_core_t st_reg;
  rcs_core_t st_next;
  logic ext_level;
  logic ext_rise;
  logic access;
  logic trim_hit;

  // Reset-delay cycles for a start-up code; reserved code gets the long delay
  function automatic logic [31:0] reset_delay(input logic [1:0] code);
    logic [31:0] d;
    d = 32'(LONG_CYC);
    unique case (code)
      SUT_NONE: d = 32'h0000_0000;
      SUT_SHORT: d = 32'(SHORT_CYC);
      SUT_LONG: d = 32'(LONG_CYC);
      default: d = 32'(LONG_CYC);
    endcase
    return d;
  endfunction

  // Legal source codes are external and the four RC ranges
  function automatic logic src_legal(input logic [3:0] code);
    return (code <= SRC_RC8);
  endfunction

  // Crystal input pin is asynchronous: three-flop agreement filter
  rcs_pin_sync u_ext_sync (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .pin_i(crystal_input_pin_i),
    .level_o(ext_level)
  );

  assign ext_rise = ext_level & ~st_reg.ext_prev;
  assign access = psel_i & penable_i;
  assign trim_hit = (paddr_i == OFF_TRIM) & ~legacy_mode_i;

  // Main next-state logic
  always_comb begin
    st_next = st_reg;
    st_next.ext_prev = ext_level;
    st_next.opt = oscillator_option_fuse_i;
    unique case (st_reg.state)
      ST_RESET_WAIT: begin
        // Count core cycles of the reset time-out, then open the clock
        if (st_reg.count >= st_reg.target) begin
          st_next.state = ST_RUN;
          st_next.clk_en = 1'b1;
          st_next.count = 32'h0000_0000;
        end else begin
          st_next.count = st_reg.count + 32'h0000_0001;
        end
      end
      ST_RUN: begin
        if (sleep_i) begin
          st_next.state = ST_SLEEP;
          st_next.clk_en = 1'b0;
        end
      end
      ST_SLEEP: begin
        if (wake_i) begin
          st_next.state = ST_WAKE_WAIT;
          st_next.count = 32'h0000_0000;
        end
      end
      ST_WAKE_WAIT: begin
        // Count source cycles: RC counts core edges, external counts pin rises
        if (st_reg.src != SRC_EXT || ext_rise) begin
          st_next.count = st_reg.count + 32'h0000_0001;
        end
        if (st_reg.count >= 32'(WAKE_CK)) begin
          st_next.state = ST_RUN;
          st_next.clk_en = 1'b1;
          st_next.wake_log = st_reg.wake_log + 32'h0000_0001;
          st_next.count = 32'h0000_0000;
        end
      end
    endcase
    // Register write, taken in the access phase
    if (access && pwrite_i && trim_hit && pstrb_i[0]) begin
      st_next.trim = pwdata_i[7:0];
    end
    // Read data registered for the access phase
    st_next.rdata = 32'h0000_0000;
    if (psel_i && !penable_i && !pwrite_i) begin
      unique case (paddr_i)
        OFF_TRIM: st_next.rdata = legacy_mode_i ? 32'h0000_0000 : {24'h00_0000, st_reg.trim};
        OFF_FUSE: st_next.rdata = {25'h000_0000, st_reg.opt, st_reg.startup_time_fuses, st_reg.src};
        OFF_STATUS: st_next.rdata = {28'h000_0000, st_reg.src_bad, st_reg.clk_en,
                                     st_reg.state == ST_SLEEP, st_reg.state == ST_RUN};
        OFF_CTRL: st_next.rdata = st_reg.wake_log;
        default: st_next.rdata = 32'h0000_0000;
      endcase
    end
  end

  // State register; reset loads fuses and factory trim on the first clocked edge
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      st_reg.state <= ST_RESET_WAIT;
      st_reg.trim <= factory_cal_byte_i;
      st_reg.src <= clock_source_select_fuses_i;
      st_reg.startup_time_fuses <= startup_time_fuses_i;
      st_reg.opt <= oscillator_option_fuse_i;
      st_reg.src_bad <= ~src_legal(clock_source_select_fuses_i);
      st_reg.count <= 32'h0000_0000;
      st_reg.target <= reset_delay(startup_time_fuses_i);
      st_reg.clk_en <= 1'b0;
      st_reg.ext_prev <= 1'b0;
      st_reg.rdata <= 32'h0000_0000;
      st_reg.wake_log <= 32'h0000_0000;
    end else begin
      st_reg <= st_next;
    end
  end

  // Source mux: RC for codes 1..4, pin for code 0
  logic src_clk;
  assign src_clk = (st_reg.src == SRC_EXT) ? crystal_input_pin_i : rc_osc_clk_i;

  rcs_clk_gate u_gate (
    .clk_i(src_clk),
    .rst_i(rst_i),
    .enable_i(st_reg.clk_en),
    .gated_o(sys_clk_o)
  );

  // Oscillator controls
  assign trim_value_o = st_reg.trim;
  assign rc_range_o = 2'(st_reg.src - SRC_RC1);
  assign rc_enable_o = 1'b1;
  assign ext_select_o = (st_reg.src == SRC_EXT);
  // NVM timing always from the RC, watchdog always from its own oscillator
  assign nvm_timing_clk_o = rc_osc_clk_i;
  assign watchdog_clk_o = watchdog_osc_clk_i;
  assign clock_ready_o = st_reg.clk_en;
  // Flag illegal or option-fuse misuse with the RC source
  assign fuse_error_o = st_reg.src_bad | (st_reg.opt & (st_reg.src != SRC_EXT));

  // APB answers in the access cycle, zero wait states
  assign pready_o = 1'b1;
  assign pslverr_o = 1'b0;
  assign prdata_o = st_reg.rdata;
endmodule
`default_nettype wire

// File: src/rcs_pkg.sv
// Package for the internal RC / external clock select block.
// Assumes a 100 MHz core clock; all offsets and counts live here.
package rcs_pkg;
  // Core clock period in picoseconds
  localparam int unsigned CORE_PERIOD_PS = 10000;
  // Register byte offsets on the APB slave
  localparam logic [7:0] OFF_TRIM = 8'h00;
  localparam logic [7:0] OFF_FUSE = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_CTRL = 8'h0C;
  // Source-select fuse codes
  localparam logic [3:0] SRC_EXT = 4'h0;
  localparam logic [3:0] SRC_RC1 = 4'h1;
  localparam logic [3:0] SRC_RC2 = 4'h2;
  localparam logic [3:0] SRC_RC4 = 4'h3;
  localparam logic [3:0] SRC_RC8 = 4'h4;
  // Delivered fuse values
  localparam logic [3:0] SRC_RESET = 4'h1;
  localparam logic [1:0] SUT_RESET = 2'h2;
  // Start-up field codes
  localparam logic [1:0] SUT_NONE = 2'h0;
  localparam logic [1:0] SUT_SHORT = 2'h1;
  localparam logic [1:0] SUT_LONG = 2'h2;
  // Wake-up source cycles from power-down or power-save
  localparam int unsigned WAKE_CK = 6;
  // Extra reset delays as printed: short in tenths of a millisecond, long in microseconds
  localparam int unsigned DLY_SHORT_US_X10 = 41;
  localparam int unsigned DLY_LONG_US = 65000;
  // Cycle counts of the core clock (longest times round down)
  // Cycles per microsecond taken first so the products stay inside 32 bits
  localparam int unsigned DLY_SHORT_CYC = DLY_SHORT_US_X10 * 100 * (1000000 / CORE_PERIOD_PS);
  localparam int unsigned DLY_LONG_CYC = DLY_LONG_US * (1000000 / CORE_PERIOD_PS);
  // Trim reset value before the factory byte lands
  localparam logic [7:0] TRIM_RESET = 8'h00;
  // Signature row address of the 1 MHz calibration byte
  localparam logic [7:0] SIG_CAL_ADDR = 8'h00;
  // Three-stage pin synchroniser depth
  localparam int unsigned SYNC_STAGES = 3;
endpackage

// File: src/rcs_pin_sync.sv
// Three-flop synchroniser for a pin input.
// Assumes pin is asynchronous to core_clk_i; output changes once stages 2 and 3 agree.
`timescale 1ns/1ps
`default_nettype none
module rcs_pin_sync (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic pin_i,
  output logic level_o
);
  import rcs_pkg::*;
  typedef struct packed {
    logic [SYNC_STAGES-1:0] sh;
    logic level;
  } rcs_sync_t;
  rcs_sync_t st_reg;
  rcs_sync_t st_next;

  // Stage 1 feeds only stage 2; agreement of 2 and 3 moves the level
  always_comb begin
    st_next = st_reg;
    st_next.sh = {st_reg.sh[SYNC_STAGES-2:0], pin_i};
    if (st_reg.sh[1] == st_reg.sh[2]) begin
      st_next.level = st_reg.sh[2];
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign level_o = st_reg.level;
endmodule
`default_nettype wire

// File: src/rcs_clk_gate.sv
// Glitch-free gate for the selected system clock.
// Assumes enable_i is registered in the core domain; latch-free flop on falling edge.
`timescale 1ns/1ps
`default_nettype none
module rcs_clk_gate (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic enable_i,
  output logic gated_o
);
  logic en_reg;

  // Enable changes only while the clock is low, so no runt pulses
  always_ff @(negedge clk_i) begin
    if (rst_i) begin
      en_reg <= 1'b0;
    end else begin
      en_reg <= enable_i;
    end
  end

  assign gated_o = clk_i & en_reg;
endmodule
`default_nettype wire

// File: testbench/rcs_clock_monitor.sv
// Checker for the clock select block, bound onto its ports.
// Assumes fuses change only while reset is held.
`timescale 1ns/1ps
`default_nettype none
module rcs_clock_monitor #(
  parameter int unsigned SHORT_CYC = 10,
  parameter int unsigned LONG_CYC = 20
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  input wire logic [3:0] clock_source_select_fuses_i,
  input wire logic [1:0] startup_time_fuses_i,
  input wire logic legacy_mode_i,
  input wire logic [7:0] factory_cal_byte_i,
  input wire logic sleep_i,
  input wire logic wake_i,
  input wire logic rc_osc_clk_i,
  input wire logic watchdog_osc_clk_i,
  input wire logic [7:0] trim_value_o,
  input wire logic [1:0] rc_range_o,
  input wire logic ext_select_o,
  input wire logic nvm_timing_clk_o,
  input wire logic watchdog_clk_o,
  input wire logic clock_ready_o
);
  import rcs_pkg::*;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  logic boot_reg;
  int unsigned boot_cnt_reg;
  int unsigned boot_tgt;
  logic [7:0] wr_low;
  wire logic trim_wr = psel_i && penable_i && pwrite_i && paddr_i == OFF_TRIM && pstrb_i[0];
  assign wr_low = pwdata_i[7:0];
  // Reserved start-up code waits as long as the long one
  assign boot_tgt = (startup_time_fuses_i == SUT_NONE) ? 0 :
    (startup_time_fuses_i == SUT_SHORT) ? SHORT_CYC : LONG_CYC;
  // Cycles since reset release, so a stuck start-up count shows up
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      boot_reg <= 1'b1;
      boot_cnt_reg <= 0;
    end else begin
      boot_cnt_reg <= boot_cnt_reg + 1;
      if (clock_ready_o) boot_reg <= 1'b0;
    end
  end
  a_rc_range_code: assert property (!$past(rst_i) && clock_source_select_fuses_i inside {[1:4]}
    |-> rc_range_o == clock_source_select_fuses_i - 1) else $error("rc range wrong");
  a_ext_source_sel: assert property (!$past(rst_i)
    |-> ext_select_o == (clock_source_select_fuses_i == SRC_EXT)) else $error("ext select wrong");
  a_trim_reset_load: assert property ($past(rst_i)
    |-> trim_value_o == $past(factory_cal_byte_i)) else $error("trim not loaded");
  a_trim_write_take: assert property (trim_wr && !legacy_mode_i
    |=> trim_value_o == $past(wr_low)) else $error("trim write lost");
  a_legacy_trim_hold: assert property (trim_wr && legacy_mode_i
    |=> $stable(trim_value_o)) else $error("trim written in legacy mode");
  a_nvm_clock_src: assert property (nvm_timing_clk_o == rc_osc_clk_i)
    else $error("nvm clock not rc");
  a_watchdog_clock_src: assert property (watchdog_clk_o == watchdog_osc_clk_i)
    else $error("watchdog clock wrong");
  a_boot_delay_len: assert property (boot_reg && $rose(clock_ready_o)
    |-> boot_cnt_reg inside {[boot_tgt:boot_tgt + 2]}) else $error("start-up delay wrong");
  a_rc_wake_len: assert property (wake_i && !clock_ready_o && !boot_reg && !ext_select_o
    |-> !clock_ready_o [*5] ##[1:4] clock_ready_o) else $error("wake delay wrong");
  a_sleep_gate_off: assert property (sleep_i && clock_ready_o |=> ##[0:1] !clock_ready_o)
    else $error("clock not gated in sleep");
  c_boot: cover property (boot_reg && $rose(clock_ready_o));
  c_wake: cover property (wake_i && !clock_ready_o);
  c_legacy: cover property (trim_wr && legacy_mode_i);
endmodule
bind rcs_clock_select rcs_clock_monitor #(.SHORT_CYC(SHORT_CYC), .LONG_CYC(LONG_CYC)) u_mon (
  .core_clk_i, .rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .pstrb_i,
  .clock_source_select_fuses_i, .startup_time_fuses_i, .legacy_mode_i, .factory_cal_byte_i,
  .sleep_i, .wake_i, .rc_osc_clk_i, .watchdog_osc_clk_i, .trim_value_o, .rc_range_o,
  .ext_select_o, .nvm_timing_clk_o, .watchdog_clk_o, .clock_ready_o);
`default_nettype wire

// File: testbench/rcs_ext_clk_model.sv
// External clock generator on the crystal input pin.
// Assumes the bench runs it only while the external source is chosen.
`timescale 1ns/1ps
`default_nettype none
module rcs_ext_clk_model #(
  parameter int HALF_NS = 31
) (
  input wire logic run_i,
  output logic clk_o
);
  // Fixed period keeps cycle drift nil; parked low when not running
  initial begin
    clk_o = 1'b0;
    forever begin
      #(HALF_NS);
      clk_o = run_i ? ~clk_o : 1'b0;
    end
  end
endmodule
`default_nettype wire

// File: testbench/internal_rc_and_ext_clock_select_bench.sv
// Self-checking bench for the clock select block over APB.
// Assumes start-up counts shortened to 10 and 20 core cycles.
`timescale 1ns/1ps
`default_nettype none
module internal_rc_and_ext_clock_select_bench;
  import rcs_pkg::*;
  logic clk, rst, psel, penable, pwrite, legacy, sleep, wake, rc_clk, wd_clk, ext_run, xtal;
  logic pready, pslverr, ext_o, ready_o;
  logic opt, sys_clk, fuse_err;
  logic [7:0] paddr, cal, trim_o;
  logic [31:0] pwdata, prdata, q;
  logic [3:0] src;
  logic [1:0] startup_time_fuses, range_o;
  logic [31:0] tv [3] = '{32'hffff_ff00, 32'h0000_007f, 32'h0000_00ff};
  int err_total = 0;
  int total_checks = 0;
  rcs_clock_select #(.SHORT_CYC(10), .LONG_CYC(20)) dut (
    .core_clk_i(clk), .rst_i(rst), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(4'hf), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .clock_source_select_fuses_i(src), .startup_time_fuses_i(startup_time_fuses),
    .oscillator_option_fuse_i(opt), .legacy_mode_i(legacy), .factory_cal_byte_i(cal),
    .sleep_i(sleep), .wake_i(wake), .rc_osc_clk_i(rc_clk), .crystal_input_pin_i(xtal),
    .watchdog_osc_clk_i(wd_clk), .trim_value_o(trim_o), .rc_range_o(range_o),
    .rc_enable_o(), .ext_select_o(ext_o), .nvm_timing_clk_o(), .watchdog_clk_o(),
    .sys_clk_o(sys_clk), .clock_ready_o(ready_o), .fuse_error_o(fuse_err));
  rcs_ext_clk_model #(.HALF_NS(31)) ext_gen (.run_i(ext_run), .clk_o(xtal));
  // Three unrelated clocks so edges drift past each other
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    rc_clk = 1'b0;
    forever #7 rc_clk = ~rc_clk;
  end
  initial begin
    wd_clk = 1'b0;
    forever #13 wd_clk = ~wd_clk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One APB transfer; read data taken at the edge that sees pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    for (int n = 0; n < 50 && pready !== 1'b1; n++) @(posedge clk);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_ready();
    for (int n = 0; n < 200 && ready_o !== 1'b1; n++) @(posedge clk);
    chk(ready_o, 1'b1);
  endtask
  // Source and start-up fuses and the factory byte only move while reset is held
  task automatic do_reset(input logic [3:0] s, input logic [1:0] t, input logic [7:0] c);
    @(posedge clk);
    rst <= 1'b1;
    src <= s;
    startup_time_fuses <= t;
    cal <= c;
    ext_run <= (s == SRC_EXT);
    repeat (16) @(posedge clk);
    rst <= 1'b0;
  endtask
  task automatic sleep_wake();
    @(posedge clk);
    sleep <= 1'b1;
    @(posedge clk);
    sleep <= 1'b0;
    repeat (2) @(posedge clk);
    chk(ready_o, 1'b0);
    // Slow external clock may still be in its high phase; only the RC gate is settled
    if (!ext_o) chk(sys_clk, 1'b0);
    wake <= 1'b1;
    @(posedge clk);
    wake <= 1'b0;
    wait_ready();
  endtask
  task automatic complete_run();
    if (err_total == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #200000;
    err_total++;
    complete_run();
  end
  initial begin
    rst = 1'b1;
    ext_run = 1'b0;
    {opt, psel, penable, pwrite, legacy, sleep, wake, paddr, pwdata} = '0;
    {src, startup_time_fuses, cal} = {SRC_RESET, SUT_RESET, 8'h5a};
    do_reset(SRC_RESET, SUT_RESET, 8'h5a);
    wait_ready();
    apb(1'b0, OFF_FUSE, 32'h0000_0000);
    chk(q, 32'h0000_0021);
    chk(trim_o, 8'h5a);
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, OFF_TRIM, tv[i]);
      apb(1'b0, OFF_TRIM, 32'h0000_0000);
      chk(q, {24'h00_0000, tv[i][7:0]});
      chk(trim_o, tv[i][7:0]);
    end
    apb(1'b1, 8'h10, 32'h0000_0033);
    apb(1'b0, 8'h10, 32'h0000_0000);
    chk(q, 32'h0000_0000);
    legacy <= 1'b1;
    apb(1'b1, OFF_TRIM, 32'h0000_0011);
    apb(1'b0, OFF_TRIM, 32'h0000_0000);
    chk(q, 32'h0000_0000);
    chk(trim_o, 8'hff);
    legacy <= 1'b0;
    // Every legal source code, with a fresh factory byte each reset
    for (logic [3:0] s = 0; s <= 4; s++) begin
      do_reset(s, 2'(s % 3), {4'h3, s});
      wait_ready();
      chk(trim_o, {4'h3, s});
      chk(ext_o, s == SRC_EXT);
      if (s != SRC_EXT) chk(range_o, s - 4'h1);
      sleep_wake();
    end
    // Option fuse misused with an RC source must be flagged
    opt <= 1'b1;
    do_reset(SRC_RC2, SUT_NONE, 8'h00);
    wait_ready();
    chk(fuse_err, 1'b1);
    apb(1'b0, OFF_STATUS, 32'h0000_0000);
    chk(q, 32'h0000_0005);
    complete_run();
  end
endmodule
`default_nettype wire
